// file: core/dspm_pkg.sv
`default_nettype none
package dspm_pkg;
  // ------------------------------------------------------------
  // Register indexes (printed offsets, byte address = 4 x index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h02;
  localparam logic [7:0] IDX_FRAME_ALARM = 8'h03;
  localparam logic [7:0] IDX_FEBE_CNT = 8'h04;
  localparam logic [7:0] IDX_CPAR_CNT = 8'h05;
  localparam logic [7:0] IDX_PPAR_CNT = 8'h06;
  localparam logic [7:0] IDX_AIS_SEL = 8'h20;
  localparam logic [7:0] IDX_HIGH_HOLD = 8'h3e;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FORMAT_MODE_BIT = 0;
  localparam int AIS_SEL_LO_BIT = 4;
  localparam int AIS_SEL_HI_BIT = 5;
  localparam int IRQ_OOF_BIT = 0;
  localparam int IRQ_FEBE_BIT = 1;
  localparam int IRQ_CPAR_BIT = 2;
  localparam int IRQ_PPAR_BIT = 3;
  // ------------------------------------------------------------
  // Reset values and geometry
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] AIS_SEL_RESET = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int NUM_DS2 = 7;
  localparam int HUNT_PARALLEL = 12;
  localparam int FRAME_GAP_BITS = 147;
  localparam int OOF_ERR_LIMIT = 2;
  localparam int OOF_WINDOW = 4;
  localparam real RECOVER_MS = 6.8;
  localparam real CLK_MHZ = 100.0;
  localparam int RECOVER_CYCLES = int'(RECOVER_MS * 1000.0 * CLK_MHZ);
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Per-frame DS3 events from the framer
  typedef struct packed {
    logic frame_tick;
    logic febe;
    logic fm_error;
    logic cpar_error;
    logic ppar_error;
    logic los;
    logic oof;
  } dspm_ds3_ev_t;

  // One received DS2 bit for one channel
  typedef struct packed {
    logic valid;
    logic data;
    logic frame_bit;
  } dspm_ds2_bit_t;
endpackage
`default_nettype wire

// file: core/dspm_counter.sv
`default_nettype none
module dspm_counter
  import dspm_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic inc,
  input wire logic enable,
  input wire logic saturate,
  input wire logic narrow,
  input wire logic read_clr,
  // Value
  output logic [WIDTH-1:0] value
);
  logic pending;
  logic [WIDTH-1:0] max_val;

  always_comb begin
    max_val = narrow ? WIDTH'(8'hff) : {WIDTH{1'b1}};
  end

  // ------------------------------------------------------------
  // Read clears; a count arriving in that cycle is kept, one deep
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= '0;
      pending <= 1'b0;
    end else if (read_clr) begin
      value <= '0;
      pending <= pending | (inc & enable);
    end else if (pending || (inc && enable)) begin
      pending <= pending & inc & enable;
      if (value != max_val) begin
        value <= value + WIDTH'(1);
      end else if (!saturate) begin
        value <= '0;
      end
    end
  end
endmodule // dspm_counter
`default_nettype wire

// file: core/dspm_ds2_framer.sv
`default_nettype none
module dspm_ds2_framer
  import dspm_pkg::*;
#(
  parameter int GAP = FRAME_GAP_BITS,
  parameter int LANES = HUNT_PARALLEL
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Received DS2 stream
  input wire dspm_ds2_bit_t rx,
  // Alarm
  output logic out_of_frame
);
  typedef enum logic [1:0] {
    ST_INFRAME = 2'b00,
    ST_HUNT = 2'b01,
    ST_CONFIRM = 2'b10
  } dspm_fr_st_t;

  dspm_fr_st_t state;
  logic [OOF_WINDOW-1:0] err_hist;
  logic [2:0] err_sum;
  logic [LANES-1:0] ref_bits;
  logic [LANES-1:0] lane_hit;
  logic [8:0] pos;
  logic [3:0] lane;
  logic expect_bit;
  logic confirm_bit;

  // Framing bit alternates 0101; error when it differs from the expected bit
  always_comb begin
    err_sum = 3'(err_hist[0]) + 3'(err_hist[1]) + 3'(err_hist[2]) + 3'(err_hist[3]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_HUNT;
      out_of_frame <= 1'b1;
      err_hist <= '0;
      expect_bit <= 1'b0;
      ref_bits <= '0;
      lane_hit <= '0;
      pos <= '0;
      lane <= '0;
      confirm_bit <= 1'b0;
    end else if (rx.valid) begin
      unique case (state)
        ST_INFRAME: begin
          if (rx.frame_bit) begin
            err_hist <= {err_hist[2:0], rx.data != expect_bit};
            // Flywheel: one bad bit must not count as two errors
            expect_bit <= ~expect_bit;
            if (err_sum + 3'(rx.data != expect_bit) - 3'(err_hist[3]) >=
                3'(OOF_ERR_LIMIT)) begin
              state <= ST_HUNT;
              out_of_frame <= 1'b1;
              pos <= '0;
            end
          end
        end
        ST_HUNT: begin
          // Twelve candidate lanes sampled, then checked 147 bits on
          if (pos < 9'(LANES)) begin
            ref_bits[pos[3:0]] <= rx.data;
          end else if (pos >= 9'(GAP) && pos < 9'(GAP + LANES)) begin
            lane_hit[pos[3:0] - 4'(GAP % 16)] <= rx.data != ref_bits[4'(pos - 9'(GAP))];
          end
          if (pos == 9'(GAP + LANES)) begin
            pos <= '0;
            if (|lane_hit) begin
              state <= ST_CONFIRM;
              for (int i = LANES - 1; i >= 0; i--) begin
                if (lane_hit[i]) begin
                  lane <= 4'(i);
                  confirm_bit <= ref_bits[i];
                end
              end
            end
            lane_hit <= '0;
          end else begin
            pos <= pos + 9'd1;
          end
        end
        ST_CONFIRM: begin
          // One more frame of agreement before the alarm drops
          pos <= pos + 9'd1;
          // Next framing bit of the hit lane, counted from the hunt's end
          if (pos == 9'(GAP - LANES - 1) + 9'(lane)) begin
            pos <= '0;
            if (rx.data == confirm_bit) begin
              state <= ST_INFRAME;
              out_of_frame <= 1'b0;
              err_hist <= '0;
              expect_bit <= ~rx.data;
            end else begin
              state <= ST_HUNT;
            end
          end
        end
        default: state <= ST_HUNT;
      endcase
    end
  end
endmodule // dspm_ds2_framer
`default_nettype wire

// file: core/dspm_perf_top.sv
`default_nettype none
module dspm_perf_top
  import dspm_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compatibility pin (asynchronous)
  input wire logic narrow_count_pin,
  // DS3 events, same clock
  input wire dspm_ds3_ev_t ds3_ev,
  // DS2 receive streams, same clock
  input wire dspm_ds2_bit_t [NUM_DS2-1:0] ds2_rx,
  // DS1 AIS request per DS2 channel, four tributaries each
  output logic [NUM_DS2*4-1:0] ds1_ais_insert,
  // Interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] ais_sel;
  logic [7:0] count_high_byte_hold;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic narrow_meta;
  logic narrow_sync;
  logic [NUM_DS2-1:0] ds2_frame_loss_flag;
  logic [NUM_DS2-1:0] oof_prev;
  logic [CNT_WIDTH-1:0] far_end_error_count_bits;
  logic [CNT_WIDTH-1:0] cparity_count_bits;
  logic [CNT_WIDTH-1:0] pparity_count_bits;
  logic format_mode_select;
  logic ds3_ok;
  logic inc_fb;
  logic inc_cp;
  logic inc_pp;
  logic en_fb;
  logic [2:0] rd_clr;

  // AXI state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [7:0] ar_idx;
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_ok;

  // ------------------------------------------------------------
  // Compatibility pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_meta <= 1'b0;
      narrow_sync <= 1'b0;
    end else begin
      narrow_meta <= narrow_count_pin;
      narrow_sync <= narrow_meta;
    end
  end

  // ------------------------------------------------------------
  // DS2 framers and AIS
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_DS2; g++) begin : g_ds2
    dspm_ds2_framer #(
      .GAP(FRAME_GAP_BITS),
      .LANES(HUNT_PARALLEL)
    ) u_framer (
      .aclk(aclk),
      .aresetn(aresetn),
      .rx(ds2_rx[g]),
      .out_of_frame(ds2_frame_loss_flag[g])
    );
  end

  // Flag bit n carries channel n+1; select 00 or 01 means bit 5 clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ds1_ais_insert <= '0;
    end else begin
      for (int c = 0; c < NUM_DS2; c++) begin
        ds1_ais_insert[c*4 +: 4] <=
          {4{ds2_frame_loss_flag[c] & ~ais_sel[AIS_SEL_HI_BIT]}};
      end
    end
  end

  // ------------------------------------------------------------
  // Performance counters
  // ------------------------------------------------------------
  always_comb begin
    format_mode_select = ctrl[FORMAT_MODE_BIT];
    ds3_ok = ~ds3_ev.los & ~ds3_ev.oof;
    // C-bit mode counts FEBE frames; M13 counts F/M errors outside OOF
    inc_fb = format_mode_select ? ds3_ev.fm_error : (ds3_ev.febe & ds3_ev.frame_tick);
    en_fb = format_mode_select ? ~ds3_ev.oof : 1'b1;
    inc_cp = format_mode_select ? ds3_ev.frame_tick : ds3_ev.cpar_error;
    inc_pp = ds3_ev.ppar_error;
  end

  dspm_counter #(.WIDTH(CNT_WIDTH)) u_cnt_fb (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(inc_fb),
    .enable(en_fb),
    .saturate(format_mode_select),
    .narrow(narrow_sync),
    .read_clr(rd_clr[0]),
    .value(far_end_error_count_bits)
  );

  dspm_counter #(.WIDTH(CNT_WIDTH)) u_cnt_cp (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(inc_cp),
    .enable(ds3_ok),
    .saturate(1'b0),
    .narrow(narrow_sync),
    .read_clr(rd_clr[1]),
    .value(cparity_count_bits)
  );

  dspm_counter #(.WIDTH(CNT_WIDTH)) u_cnt_pp (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(inc_pp),
    .enable(ds3_ok),
    .saturate(1'b0),
    .narrow(narrow_sync),
    .read_clr(rd_clr[2]),
    .value(pparity_count_bits)
  );

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx == IDX_CTRL || aw_idx == IDX_AIS_SEL ||
                        aw_idx == IDX_IRQ_MASK) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      ais_sel <= AIS_SEL_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_fire && wstrb_q[0]) begin
      if (aw_idx == IDX_CTRL) ctrl <= wdata_q[7:0];
      if (aw_idx == IDX_AIS_SEL) ais_sel <= wdata_q[7:0];
      if (aw_idx == IDX_IRQ_MASK) irq_mask <= wdata_q[3:0];
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path; side effects happen at address acceptance
  // ------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    rd_clr = 3'b000;
    unique case (ar_idx)
      IDX_CTRL: rd_word[7:0] = ctrl;
      IDX_FRAME_ALARM: rd_word[NUM_DS2-1:0] = ds2_frame_loss_flag;
      IDX_FEBE_CNT: begin
        rd_word[7:0] = far_end_error_count_bits[7:0];
        rd_clr[0] = rd_fire;
      end
      IDX_CPAR_CNT: begin
        rd_word[7:0] = cparity_count_bits[7:0];
        rd_clr[1] = rd_fire;
      end
      IDX_PPAR_CNT: begin
        rd_word[7:0] = pparity_count_bits[7:0];
        rd_clr[2] = rd_fire;
      end
      IDX_AIS_SEL: rd_word[7:0] = ais_sel;
      IDX_HIGH_HOLD: rd_word[7:0] = count_high_byte_hold;
      IDX_IRQ_STATUS: rd_word[3:0] = irq_status;
      IDX_IRQ_MASK: rd_word[3:0] = irq_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // High byte is captured with the low-byte read; left unchanged in narrow mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_high_byte_hold <= '0;
    end else if (!narrow_sync) begin
      if (rd_clr[0]) count_high_byte_hold <= far_end_error_count_bits[15:8];
      if (rd_clr[1]) count_high_byte_hold <= cparity_count_bits[15:8];
      if (rd_clr[2]) count_high_byte_hold <= pparity_count_bits[15:8];
    end
  end

  // ------------------------------------------------------------
  // Interrupts: sticky status, cleared by read, set wins
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Framers leave reset in alarm; no false new-alarm edge
      oof_prev <= '1;
      irq_status <= '0;
    end else begin
      oof_prev <= ds2_frame_loss_flag;
      irq_status <= ((rd_fire && ar_idx == IDX_IRQ_STATUS) ? 4'h0 : irq_status) |
        {inc_pp & ds3_ok, inc_cp & ds3_ok, inc_fb & en_fb,
         |(ds2_frame_loss_flag & ~oof_prev)};
    end
  end

  assign irq = |(irq_status & irq_mask);
endmodule // dspm_perf_top
`default_nettype wire

// file: bench/dspm_perf_chk.sv
`default_nettype none
module dspm_perf_chk
  import dspm_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Line side
  input wire logic narrow_count_pin,
  input wire dspm_ds3_ev_t ds3_ev,
  input wire logic [NUM_DS2*4-1:0] ds1_ais_insert
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Shadow of the P-bit counter
  // ----
  logic [15:0] cnt;
  logic [15:0] seen;
  logic hold_ok;
  logic ev;
  logic ar;
  logic ar_pp;
  assign ev = ds3_ev.ppar_error && !ds3_ev.los && !ds3_ev.oof;
  assign ar = s_axi_arvalid && s_axi_arready;
  assign ar_pp = ar && s_axi_araddr == 32'h18;
  // Only the low byte is compared, so the 8-bit wrap matches as well
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 16'h0000;
      seen <= 16'h0000;
    end else if (ar_pp) begin
      seen <= cnt;
      cnt <= {15'h0000, ev};
    end else begin
      cnt <= cnt + {15'h0000, ev};
    end
  end
  // Hold byte is trusted only after a wide-mode read of this counter
  always_ff @(posedge aclk) begin
    if (!aresetn || narrow_count_pin) begin
      hold_ok <= 1'b0;
    end else if (ar && s_axi_araddr[7:4] == 4'h1) begin
      hold_ok <= ar_pp;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ppar_read_clear: assert property (
    ar_pp |=> s_axi_rvalid && s_axi_rdata[7:0] == seen[7:0]
  ) else $error("P-bit counter read value wrong");
  a_hold_high_byte: assert property (
    ar && s_axi_araddr == 32'hf8 && hold_ok |=> s_axi_rdata[7:0] == seen[15:8]
  ) else $error("High byte hold wrong");
  a_ais_after_reset: assert property (
    $rose(aresetn) |-> ##[0:3] (&ds1_ais_insert)
  ) else $error("AIS not inserted after reset");
  a_read_answer: assert property (ar |=> s_axi_rvalid)
    else $error("Read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid
  ) else $error("Write answer late");
  a_no_ar_in_r: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answer pending");
  a_no_aw_in_b: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while answer pending");
  a_unmapped_read: assert property (
    ar && s_axi_araddr == 32'h100 |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0
  ) else $error("Unmapped read not refused");
endmodule // dspm_perf_chk

bind dspm_perf_top dspm_perf_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .narrow_count_pin(narrow_count_pin), .ds3_ev(ds3_ev),
  .ds1_ais_insert(ds1_ais_insert)
);
`default_nettype wire

// file: bench/dspm_host.sv
`default_nettype none
module dspm_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  // Read channels
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    awaddr = 32'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    araddr = 32'h0;
    arvalid = 1'b0;
  end
  // Ready lines are held high by the bench, so an answer is taken when seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    ok = bvalid;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    ok = rvalid;
  endtask
endmodule // dspm_host
`default_nettype wire

// file: bench/dspm_perf_top_tb.sv
`default_nettype none
module dspm_perf_top_tb
  import dspm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W2 = NUM_DS2 * 3;
  localparam dspm_ds3_ev_t EV_TICK = 7'h40;
  localparam dspm_ds3_ev_t EV_FEBE = 7'h60;
  localparam dspm_ds3_ev_t EV_FM = 7'h10;
  localparam dspm_ds3_ev_t EV_CP = 7'h08;
  localparam dspm_ds3_ev_t EV_PP = 7'h04;
  localparam dspm_ds3_ev_t EV_LOS = 7'h02;
  localparam dspm_ds3_ev_t EV_OOF = 7'h01;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic narrow_count_pin, irq;
  dspm_ds3_ev_t ds3_ev, lvl;
  dspm_ds2_bit_t [NUM_DS2-1:0] ds2_rx;
  logic [NUM_DS2*4-1:0] ds1_ais_insert;
  int failures, n_checks;

  dspm_perf_top #(.CNT_WIDTH(16)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .narrow_count_pin(narrow_count_pin), .ds3_ev(ds3_ev), .ds2_rx(ds2_rx),
    .ds1_ais_insert(ds1_ais_insert), .irq(irq)
  );
  dspm_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
  );

  // ----
  // Clock and line noise
  // ----
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  // Noise could lock a framer, so DS2 alarms are checked only soon after a reset
  always @(posedge aclk) begin
    ds2_rx <= W2'($urandom);
  end

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] exp_cnt(input int n, input bit narrow, input bit sat);
    int lim;
    lim = narrow ? 255 : 65535;
    if (sat && n > lim) return lim[15:0];
    return n[15:0] & (narrow ? 16'h00ff : 16'hffff);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic rd_b(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ok;
    u_host.rd(a, d, r, ok);
    if (!ok) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd_b(a, d, r);
    chk({24'h0, d[7:0]}, {24'h0, e[7:0]});
  endtask
  task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    bit ok;
    u_host.wr(a, d, r, ok);
    if (!ok) begin
      failures++;
      end_of_test();
    end
    chk({30'h0, r}, {30'h0, e});
  endtask
  // Two cycles per event keeps a held increment from meeting a second one
  task automatic pulse(input dspm_ds3_ev_t e, input int n);
    repeat (n) begin
      ds3_ev <= e | lvl;
      @(posedge aclk);
      ds3_ev <= lvl;
      @(posedge aclk);
    end
  endtask
  task automatic set_lvl(input dspm_ds3_ev_t l);
    lvl = l;
    ds3_ev <= l;
    @(posedge aclk);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n1, n2, n3, nl, tot;
    aresetn = 1'b0;
    narrow_count_pin = 1'b0;
    ds3_ev = '0;
    lvl = '0;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'hb032));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(32'h0c, 16'h007f);
    for (int s = 0; s < 4; s++) begin
      wr_chk(32'h80, 32'(s) << AIS_SEL_LO_BIT, AXI_OKAY);
      repeat (3) @(posedge aclk);
      chk({4'h0, ds1_ais_insert}, (s < 2) ? 32'h0fffffff : 32'h0);
    end
    wr_chk(32'h0c, 32'h0, AXI_SLVERR);
    rd_b(32'h100, d, r);
    chk({r, d[29:0]}, {AXI_SLVERR, 30'h0});
    n1 = $urandom_range(40, 1);
    n2 = $urandom_range(40, 1);
    n3 = $urandom_range(40, 1);
    nl = $urandom_range(9, 1);
    wr_chk(32'h08, 32'h0, AXI_OKAY);
    pulse(EV_FEBE, n1);
    pulse(EV_CP, n2);
    pulse(EV_PP, n3);
    set_lvl(EV_LOS);
    pulse(EV_CP | EV_PP, nl);
    set_lvl(EV_OOF);
    pulse(EV_CP | EV_PP, nl);
    set_lvl('0);
    rd_chk(32'h10, exp_cnt(n1, 0, 0));
    rd_chk(32'h14, exp_cnt(n2, 0, 0));
    rd_chk(32'h18, exp_cnt(n3, 0, 0));
    rd_chk(32'h18, 16'h0);
    wr_chk(32'h08, 32'h1, AXI_OKAY);
    pulse(EV_TICK, n1);
    pulse(EV_FM, n2);
    set_lvl(EV_OOF);
    pulse(EV_FM | EV_TICK, nl);
    set_lvl('0);
    rd_chk(32'h10, exp_cnt(n2, 0, 1));
    rd_chk(32'h14, exp_cnt(n1, 0, 0));
    pulse(EV_PP, 300);
    rd_chk(32'h18, exp_cnt(300, 0, 0));
    rd_chk(32'hf8, exp_cnt(300, 0, 0) >> 8);
    narrow_count_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    pulse(EV_FM, 260);
    pulse(EV_PP, 260);
    rd_chk(32'h10, exp_cnt(260, 1, 1));
    rd_chk(32'h18, exp_cnt(260, 1, 0));
    narrow_count_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    tot = 0;
    fork
      pulse(EV_PP, 100);
      repeat (20) begin
        rd_b(32'h18, d, r);
        tot += int'(d[7:0]);
        repeat ($urandom_range(9, 1)) @(posedge aclk);
      end
    join
    rd_b(32'h18, d, r);
    tot += int'(d[7:0]);
    chk(32'(tot), 32'h64);
    rd_b(32'hc0, d, r);
    wr_chk(32'hc4, 32'h1 << IRQ_PPAR_BIT, AXI_OKAY);
    chk({31'h0, irq}, 32'h0);
    pulse(EV_PP, 1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd_b(32'hc0, d, r);
    chk(d & 32'h8, 32'h8);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    pulse(EV_PP, 5);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(32'h18, 16'h0);
    rd_chk(32'h0c, 16'h007f);
    end_of_test();
  end
endmodule // dspm_perf_top_tb
`default_nettype wire
